// ==== pcsia_map.vh ====
`ifndef PCSIA_MAP_VH
`define PCSIA_MAP_VH

// register byte offsets on the wishbone bus
`define PCSIA_OFS_PC_LOW_BYTE 6'h00
`define PCSIA_OFS_PC_HIGH_LATCH 6'h04
`define PCSIA_OFS_INDIRECT_POINTER 6'h08
`define PCSIA_OFS_INDIRECT_WINDOW 6'h0C
`define PCSIA_OFS_BANK_CTRL 6'h10
`define PCSIA_OFS_PC_VIEW 6'h14

// widths
`define PCSIA_PC_W 13
`define PCSIA_LATCH_W 5
`define PCSIA_DADDR_W 9
`define PCSIA_LIT_W 11

// field positions
`define PCSIA_BANK_BIT 0

// reset values
`define PCSIA_RST_PC 13'h0000
`define PCSIA_RST_BYTE 8'h00
`define PCSIA_RST_LATCH 5'h00
`define PCSIA_RST_SP 3'h0

// file address at which the indirect window itself sits
`define PCSIA_WIN_FILE_ADDR 8'h00
// address the core branches to when an interrupt is taken
`define PCSIA_INT_VECTOR 13'h0004

// bus sequencer states
`define PCSIA_ST_IDLE 2'h0
`define PCSIA_ST_MEM 2'h1
`define PCSIA_ST_ACK 2'h2

`endif

// ==== pcsia_core.v ====
`include "pcsia_map.vh"
`default_nettype none

// Operation
// - 13-bit counter; low byte read and written, whole counter readable at the view offset; a bus write loads the top five bits from the latch.
// - every reset clears the whole program counter.
// - writing the low byte loads the top five bits from the latch together.
// - call and jump take the two top bits from latch bits 4 and 3.
// - return stack of eight entries, 13 bits each, outside program and data space.
// - the stack pointer is never visible or writable.
// - call and interrupt vectoring push the program counter.
// - return, return with literal and return from interrupt pop into the counter.
// - push and pop never alter the high latch.
// - the stack is circular; the ninth push overwrites the first.
// - no overflow or underflow indication exists.
// - the window has no storage; accesses go to the location the pointer selects.
// - reading the window through itself returns zero.
// - writing the window through itself stores nothing.
// - indirect address is bank bit above the 8-bit pointer, nine bits.
module pcsia_core #(
	parameter STACK_DEPTH = 8,
	parameter SP_W = 3
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [5:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire dec_fetch_i,
	input wire dec_jump_i,
	input wire dec_call_i,
	input wire [10:0] dec_lit_i,
	input wire dec_int_i,
	input wire dec_return_i,
	input wire dec_return_with_literal_i,
	input wire dec_return_from_interrupt_i,
	output reg [12:0] pc_o,
	output reg mem_req_o,
	output reg mem_we_o,
	output reg [8:0] mem_addr_o,
	output reg [7:0] mem_wdata_o,
	input wire [7:0] mem_rdata_i
);

	function [`PCSIA_PC_W-1:0] pcsia_inc;
		input [`PCSIA_PC_W-1:0] v;
		begin
			pcsia_inc = v + 13'h0001;
		end
	endfunction

	function pcsia_hit;
		input [5:0] adr;
		input [5:0] ofs;
		begin
			pcsia_hit = (adr == ofs);
		end
	endfunction

	reg [`PCSIA_PC_W-1:0] pc_r;
	reg [`PCSIA_PC_W-1:0] pc_nxt;
	reg [`PCSIA_LATCH_W-1:0] pc_high_latch_r;
	reg [7:0] indirect_pointer_r;
	reg indirect_bank_bit_r;
	// no port or register reads this pointer back
	reg [SP_W-1:0] sp_r;
	reg [`PCSIA_PC_W-1:0] stack_r [0:STACK_DEPTH-1];
	reg [1:0] state_r;
	reg win_we_r;

	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && (state_r == `PCSIA_ST_IDLE);
	wire wr_lo = req && wb_we_i && wb_sel_i[0];
	wire hit_pcl = pcsia_hit(wb_adr_i, `PCSIA_OFS_PC_LOW_BYTE);
	wire hit_lat = pcsia_hit(wb_adr_i, `PCSIA_OFS_PC_HIGH_LATCH);
	wire hit_ptr = pcsia_hit(wb_adr_i, `PCSIA_OFS_INDIRECT_POINTER);
	wire hit_win = pcsia_hit(wb_adr_i, `PCSIA_OFS_INDIRECT_WINDOW);
	wire hit_bank = pcsia_hit(wb_adr_i, `PCSIA_OFS_BANK_CTRL);
	wire hit_view = pcsia_hit(wb_adr_i, `PCSIA_OFS_PC_VIEW);
	wire win_self = (indirect_pointer_r == `PCSIA_WIN_FILE_ADDR);
	wire do_push = dec_int_i || dec_call_i;
	wire do_pop = dec_return_i || dec_return_with_literal_i || dec_return_from_interrupt_i;
	wire [SP_W-1:0] sp_dec = sp_r - {{(SP_W-1){1'b0}}, 1'b1};

	// interrupt, call, jump and pop outrank a bus write of the low byte landing in the same cycle; the write outranks a fetch
	always @* begin
		pc_nxt = pc_r;
		if (dec_int_i) begin
			pc_nxt = `PCSIA_INT_VECTOR;
		end else if (dec_call_i || dec_jump_i) begin
			pc_nxt = {pc_high_latch_r[4:3], dec_lit_i};
		end else if (do_pop) begin
			// wraps silently to whatever entry sits below the pointer
			pc_nxt = stack_r[sp_dec];
		end else if (wr_lo && hit_pcl) begin
			pc_nxt = {pc_high_latch_r, wb_dat_i[7:0]};
		end else if (dec_fetch_i) begin
			pc_nxt = pcsia_inc(pc_r);
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			pc_r <= `PCSIA_RST_PC;
			pc_o <= `PCSIA_RST_PC;
		end else begin
			pc_r <= pc_nxt;
			pc_o <= pc_nxt;
		end
	end

	// stack pointer only moves; nothing flags wrap in either direction
	always @(posedge clk_i) begin
		if (rst_i) begin
			sp_r <= `PCSIA_RST_SP;
		end else if (do_push) begin
			stack_r[sp_r] <= pc_r;
			sp_r <= sp_r + {{(SP_W-1){1'b0}}, 1'b1};
		end else if (do_pop) begin
			sp_r <= sp_dec;
		end
	end

	// the latch is written only by the bus, never by stack traffic
	always @(posedge clk_i) begin
		if (rst_i) begin
			pc_high_latch_r <= `PCSIA_RST_LATCH;
			indirect_pointer_r <= `PCSIA_RST_BYTE;
			indirect_bank_bit_r <= 1'b0;
		end else if (wr_lo) begin
			if (hit_lat) begin
				pc_high_latch_r <= wb_dat_i[`PCSIA_LATCH_W-1:0];
			end
			if (hit_ptr) begin
				indirect_pointer_r <= wb_dat_i[7:0];
			end
			if (hit_bank) begin
				indirect_bank_bit_r <= wb_dat_i[`PCSIA_BANK_BIT];
			end
		end
	end

	// bus sequencer: plain registers ack one edge after the request,
	// window accesses that reach memory ack two edges after it
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= `PCSIA_ST_IDLE;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 9'h000;
			mem_wdata_o <= `PCSIA_RST_BYTE;
			win_we_r <= 1'b0;
		end else begin
			wb_ack_o <= 1'b0;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			case (state_r)
				`PCSIA_ST_IDLE: begin
					if (req) begin
						wb_dat_o <= 32'h00000000;
						if (hit_win && !win_self) begin
							mem_req_o <= 1'b1;
							mem_we_o <= wb_we_i && wb_sel_i[0];
							mem_addr_o <= {indirect_bank_bit_r, indirect_pointer_r};
							mem_wdata_o <= wb_dat_i[7:0];
							win_we_r <= wb_we_i;
							state_r <= `PCSIA_ST_MEM;
						end else begin
							// plain registers, unmapped offsets and a window aimed at itself; a self-aimed window read gives zero, its write is dropped
							wb_ack_o <= 1'b1;
							if (!wb_we_i) begin
								if (hit_pcl) begin
									wb_dat_o <= {24'h000000, pc_r[7:0]};
								end else if (hit_lat) begin
									wb_dat_o <= {27'h0000000, pc_high_latch_r};
								end else if (hit_ptr) begin
									wb_dat_o <= {24'h000000, indirect_pointer_r};
								end else if (hit_bank) begin
									wb_dat_o <= {31'h00000000, indirect_bank_bit_r};
								end else if (hit_view) begin
									wb_dat_o <= {19'h00000, pc_r};
								end
							end
						end
					end
				end
				`PCSIA_ST_MEM: begin
					wb_ack_o <= 1'b1;
					wb_dat_o <= win_we_r ? 32'h00000000 : {24'h000000, mem_rdata_i};
					state_r <= `PCSIA_ST_ACK;
				end
				`PCSIA_ST_ACK: begin
					state_r <= `PCSIA_ST_IDLE;
				end
				default: begin
					state_r <= `PCSIA_ST_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== pcsia_core_sva.sv ====
`include "pcsia_map.vh"
`default_nettype none
module pcsia_core_sva (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_ack_o,
	input wire logic dec_fetch_i,
	input wire logic dec_jump_i,
	input wire logic dec_call_i,
	input wire logic [10:0] dec_lit_i,
	input wire logic dec_int_i,
	input wire logic dec_return_i,
	input wire logic dec_return_with_literal_i,
	input wire logic dec_return_from_interrupt_i,
	input wire logic [12:0] pc_o,
	input wire logic mem_req_o,
	input wire logic mem_we_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// quiet cycle: no call, jump, interrupt, bus cycle, return with literal or return from interrupt; plain return is not excluded here
	wire logic q = !dec_call_i && !dec_int_i && !dec_jump_i && !wb_cyc_i && !dec_return_with_literal_i
		&& !dec_return_from_interrupt_i;
	a_reset_clears_pc: assert property (disable iff (1'b0) rst_i |=> pc_o == 13'h0000)
		else $error("pc not cleared by reset");
	a_fetch_steps_pc: assert property (dec_fetch_i && q && !dec_return_i |=> pc_o == $past(pc_o) + 13'h1)
		else $error("fetch did not step pc");
	a_call_takes_lit: assert property (dec_call_i && !dec_int_i |=> pc_o[10:0] == $past(dec_lit_i))
		else $error("call target wrong");
	a_int_vectors: assert property (dec_int_i |=> pc_o == `PCSIA_INT_VECTOR)
		else $error("interrupt vector wrong");
	a_return_restores: assert property (dec_call_i && !dec_int_i ##1 q && !dec_return_i ##1 dec_return_i && q
		|=> pc_o == $past(pc_o, 3))
		else $error("return did not restore pc");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_mem_then_ack: assert property (mem_req_o |=> wb_ack_o && !mem_req_o)
		else $error("window access not acked");
	a_write_in_req: assert property (mem_we_o |-> mem_req_o && wb_cyc_i)
		else $error("memory write outside request");
endmodule
bind pcsia_core pcsia_core_sva pcsia_core_sva_i (.clk_i, .rst_i, .wb_cyc_i, .wb_ack_o, .dec_fetch_i, .dec_jump_i,
	.dec_call_i, .dec_lit_i, .dec_int_i, .dec_return_i, .dec_return_with_literal_i, .dec_return_from_interrupt_i,
	.pc_o, .mem_req_o, .mem_we_o);
`default_nettype wire

// ==== pcsia_dmem_model.sv ====
`default_nettype none
module pcsia_dmem_model (
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [8:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:511];
	logic [7:0] last = 8'h00;
	initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'hA5;
	// idle bus shows the inverse of the last value so a stale sample cannot pass
	assign rdata_o = req_i ? mem[addr_i] : ~last;
	always @(posedge clk_i) begin
		if (req_i && we_i) mem[addr_i] <= wdata_i;
		last <= rdata_o;
	end
endmodule
`default_nettype wire

// ==== pcsia_core_tb.sv ====
`include "pcsia_map.vh"
`default_nettype none
module pcsia_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, ack, req, mwe;
	logic [5:0] adr = 6'h00;
	logic [31:0] dat = 32'h0, rd, q;
	logic [6:0] s = 7'h00;
	logic [10:0] lit = 11'h000, l;
	logic [12:0] pc_o, pc, stk [0:7];
	logic [8:0] ma;
	logic [7:0] mwd, mrd, b, p, d;
	logic [4:0] lt;
	logic [2:0] sp = 3'h0;
	int errors = 0, n_compared = 0;
	pcsia_core pcsia_core_i (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .dec_fetch_i(s[0]), .dec_jump_i(s[1]),
		.dec_call_i(s[2]), .dec_lit_i(lit), .dec_int_i(s[3]), .dec_return_i(s[4]),
		.dec_return_with_literal_i(s[5]), .dec_return_from_interrupt_i(s[6]), .pc_o, .mem_req_o(req),
		.mem_we_o(mwe), .mem_addr_o(ma), .mem_wdata_o(mwd), .mem_rdata_i(mrd));
	pcsia_dmem_model pcsia_dmem_model_i (.clk_i, .req_i(req), .we_i(mwe), .addr_i(ma), .wdata_i(mwd), .rdata_o(mrd));
	initial forever #50 clk_i = ~clk_i;
	task stop_test;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wb(input logic w, input logic [5:0] a, input logic [31:0] v);
		cyc <= 1;
		we <= w;
		adr <= a;
		dat <= v;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rd;
		cyc <= 0;
		@(posedge clk_i);
	endtask
	task dec(input logic [6:0] v, input logic [12:0] e);
		s <= v;
		@(posedge clk_i);
		s <= 7'h00;
		@(posedge clk_i);
		chk("pc", pc_o, e);
	endtask
	initial begin
		#100000;
		errors++;
		stop_test;
	end
	initial begin
		void'($urandom(32'h9a790dd4));
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		wb(0, `PCSIA_OFS_PC_VIEW, 32'h0);
		chk("pc after reset", q, 32'h0);
		lt = $urandom;
		b = $urandom;
		wb(1, `PCSIA_OFS_PC_HIGH_LATCH, lt);
		wb(1, `PCSIA_OFS_PC_LOW_BYTE, b);
		wb(0, `PCSIA_OFS_PC_VIEW, 32'h0);
		chk("pc load", q, {lt, b});
		pc = {lt, b} + 13'h1;
		dec(7'h01, pc);
		for (int i = 0; i < 9; i++) begin
			l = $urandom;
			lit <= l;
			stk[sp] = pc;
			sp++;
			pc = {lt[4:3], l};
			dec(7'h04, pc);
		end
		for (int i = 0; i < 9; i++) begin
			sp--;
			pc = stk[sp];
			dec(7'h10 << (i % 3), pc);
		end
		stk[sp] = pc;
		dec(7'h08, `PCSIA_INT_VECTOR);
		dec(7'h40, pc);
		wb(0, `PCSIA_OFS_PC_HIGH_LATCH, 32'h0);
		chk("latch kept", q, lt);
		// computed jump at the top of a page: the low byte wraps, the latch must not follow
		wb(1, `PCSIA_OFS_PC_LOW_BYTE, 32'h000000FF);
		pc = {lt, 8'hFF} + 13'h1;
		dec(7'h01, pc);
		wb(0, `PCSIA_OFS_PC_HIGH_LATCH, 32'h0);
		chk("latch no carry", q, lt);
		$display("program counter tests done");
		p = $urandom | 8'h01;
		d = $urandom;
		wb(1, `PCSIA_OFS_BANK_CTRL, 32'h1);
		wb(1, `PCSIA_OFS_INDIRECT_POINTER, p);
		wb(1, `PCSIA_OFS_INDIRECT_WINDOW, d);
		chk("mem write", pcsia_dmem_model_i.mem[{1'b1, p}], d);
		wb(0, `PCSIA_OFS_INDIRECT_WINDOW, 32'h0);
		chk("window read", q, d);
		wb(1, `PCSIA_OFS_INDIRECT_POINTER, 32'h0);
		wb(1, `PCSIA_OFS_INDIRECT_WINDOW, 32'h5A);
		chk("self write", pcsia_dmem_model_i.mem[9'h100], 8'hA5);
		wb(0, `PCSIA_OFS_INDIRECT_WINDOW, 32'h0);
		chk("self read", q, 32'h0);
		wb(0, 6'h18, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("indirect tests done");
		stop_test;
	end
endmodule
`default_nettype wire
